/* rtl/spm_pkg.sv */
// Shared constants, register map and mode encoding for the core clock and power mode controller.
// Assumes a single 100 MHz bus clock; oscillators arrive as one-cycle tick strobes on that clock.
package spm_pkg;

	// Clock rates
	localparam int unsigned ACLK_HZ    = 100_000_000;
	localparam int unsigned FAST_RC_HZ = 8_000_000;
	localparam int unsigned LOW_RC_HZ  = 32_000;

	// Register map, byte addresses on a 4-bit AXI4-Lite address
	localparam int unsigned AXI_AW      = 4;
	localparam logic [3:0]  ADDR_CTRL   = 4'h0;
	localparam logic [3:0]  ADDR_STATUS = 4'h4;

	// Control register fields
	localparam int unsigned CTRL_W    = 9;
	localparam int unsigned CB_FS     = 0;
	localparam int unsigned CB_DIV    = 1;
	localparam int unsigned CB_DOZE   = 4;
	localparam int unsigned CB_KEEP   = 5;
	localparam int unsigned CB_BOD    = 6;
	localparam int unsigned CB_WDTEN  = 7;
	localparam int unsigned CB_WDTSUB = 8;
	localparam logic [8:0]  CTRL_RST  = 9'h001;

	// Status register fields
	localparam int unsigned ST_CUR_LOW = 7;
	localparam int unsigned ST_FAST_ON = 8;

	// Divider coding
	localparam int unsigned DIV_W       = 3;
	localparam int unsigned SHIFT_W     = 3;
	localparam int unsigned DIV_CNT_W   = 6;
	localparam logic [2:0]  SHIFT_FULL  = 3'h0;
	localparam logic [2:0]  SHIFT_BASE  = 3'h0;
	localparam logic [2:0]  DIV_LOW_MAX = 3'h1;
	localparam logic [2:0]  WDT_SHIFT   = 3'h2;

	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Wake-up settling of the fast oscillator, in fast ticks
	localparam int unsigned WAKE_SETTLE_DEF = 16;
	localparam int unsigned WAKE_CNT_W      = 8;

	typedef enum logic [6:0] {
		M_FULL  = 7'h01,
		M_LOW   = 7'h02,
		M_DOZE0 = 7'h04,
		M_DOZE1 = 7'h08,
		M_DEEP  = 7'h10,
		M_LIGHT = 7'h20,
		M_WAKE  = 7'h40
	} spm_mode_t;

	// Returns {use_low, shift}: fast select gives /1, divider 0..1 gives low clock, 2..7 gives /64../2
	function automatic logic [3:0] spm_decode_div(input logic fs, input logic [2:0] div);
		logic [3:0] r;
		r = {1'b0, SHIFT_FULL};
		if (!fs && div <= DIV_LOW_MAX) begin
			r = {1'b1, SHIFT_FULL};
		end else if (!fs) begin
			r = {1'b0, 3'(SHIFT_BASE - div)};
		end
		return r;
	endfunction : spm_decode_div

endpackage : spm_pkg

/* rtl/spm_power_mode_ctrl.sv */
// Core clock selection, peripheral clock derivation and operating mode sequencing, with AXI4-Lite control.
// Assumes oscillator ticks and the halt and wake strobes are synchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Core clock is the fast clock or the low clock, by select bits.
// - Fast clock source is crystal or fast RC, fixed by a build option.
// - Full-speed core clock is fast clock divided by 1 to 64.
// - Substitute and periodic tick clocks come from the low RC oscillator.
// - After wake-up the CPU runs on the substitute clock until fast clock settles.
// - Switching core clock to low clock stops the fast oscillator.
// - Watchdog clock selects substitute clock or core clock divided by four.
// - Periodic tick clock feeds time base and timer modules.
// - Seven modes: two running, two doze, two sleep, one wake-up.
// - Full speed: CPU on divided fast clock, side clocks all running.
// - Low-speed run: CPU on low RC, fast clock off.
// - Halt with doze-on-halt low enters a sleep mode, CPU stopped.
// - Deep sleep stops CPU and all side clocks and disables the watchdog.
// - Brownout detect on forbids deep sleep.
// - Light sleep keeps substitute and watchdog-side clocks, stops tick clock.
// - Halt, doze on, keep off: doze with oscillator stopped, side clocks run.
// - Halt, doze on, keep on: doze with system oscillator still running.
// - Both doze modes stop CPU clock; timers keep working, watchdog too except on core/4 in doze with keep off.
// - Fast RC runs at nominal 8 MHz when selected.
// - Low clock comes from internal 32 kHz RC oscillator.
module spm_power_mode_ctrl
	import spm_pkg::*;
#(
	parameter bit          USE_CRYSTAL = 1'b0,
	parameter int unsigned WAKE_SETTLE = WAKE_SETTLE_DEF
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [AXI_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output var  logic              s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output var  logic              s_axi_wready,
	output var  logic [1:0]        s_axi_bresp,
	output var  logic              s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [AXI_AW-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output var  logic              s_axi_arready,
	output var  logic [31:0]       s_axi_rdata,
	output var  logic [1:0]        s_axi_rresp,
	output var  logic              s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              crystal_osc,
	input  wire logic              fast_rc_osc,
	input  wire logic              low_rc_osc,
	input  wire logic              halt_req,
	input  wire logic              wake_req,
	output var  logic              core_clock,
	output var  logic              cpu_clock,
	output var  logic              substitute_clock,
	output var  logic              watchdog_side_clock,
	output var  logic              periodic_tick_clock,
	output var  logic              wdt_clock,
	output var  logic              fast_osc_en,
	output var  logic              wdt_disable,
	output var  logic [6:0]        mode_status
);
	typedef struct packed {
		spm_mode_t             mode;
		logic [CTRL_W-1:0]     ctrl;
		logic                  fast_en;
		logic [WAKE_CNT_W-1:0] wake_cnt;
		logic                  aw_got;
		logic [AXI_AW-1:0]     aw_addr;
		logic                  w_got;
		logic [31:0]           w_data;
		logic [3:0]            w_strb;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  rvalid;
		logic [31:0]           rdata;
		logic [1:0]            rresp;
		logic                  core_t;
		logic                  cpu_t;
		logic                  sub_t;
		logic                  wds_t;
		logic                  tbc_t;
		logic                  wdt_t;
	} spm_st_t;

	spm_st_t st_ff;
	spm_st_t nxt_st;

	logic                  fast_slow_select;
	logic [DIV_W-1:0]      core_div_select;
	logic                  doze_on_halt;
	logic                  core_clk_keep;
	logic                  brownout_detect_on;
	logic                  wdt_enable;
	logic                  wdt_src_sub;
	logic [3:0]            dec;
	logic                  req_low;
	logic                  fast_tick;
	logic                  fast_div_tick;
	logic                  core_src_tick;
	logic                  cur_low;
	logic                  core_quarter_tick;
	logic                  wdt_mux_tick;
	logic                  stop_mode;

	// Control fields
	assign fast_slow_select   = st_ff.ctrl[CB_FS];
	assign core_div_select    = st_ff.ctrl[CB_DIV +: DIV_W];
	assign doze_on_halt       = st_ff.ctrl[CB_DOZE];
	assign core_clk_keep      = st_ff.ctrl[CB_KEEP];
	assign brownout_detect_on = st_ff.ctrl[CB_BOD];
	assign wdt_enable         = st_ff.ctrl[CB_WDTEN];
	assign wdt_src_sub        = st_ff.ctrl[CB_WDTSUB];
	assign dec                = spm_decode_div(fast_slow_select, core_div_select);
	assign req_low            = dec[3];

	// A stopped oscillator gives no ticks; crystal or 8 MHz RC fixed at build time
	assign fast_tick = (USE_CRYSTAL ? crystal_osc : fast_rc_osc) & st_ff.fast_en;
	assign stop_mode = st_ff.mode inside {M_DOZE0, M_DOZE1, M_DEEP, M_LIGHT};

	spm_tick_div #(.CNT_W(DIV_CNT_W)) u_core_div (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.tick_in  (fast_tick),
		.shift    (dec[2:0]),
		.tick_out (fast_div_tick)
	);

	spm_tick_sw u_core_sw (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.tick_a   (fast_div_tick),
		.tick_b   (low_rc_osc),
		.sel      (req_low),
		.tick_out (core_src_tick),
		.cur_sel  (cur_low)
	);

	spm_tick_div #(.CNT_W(DIV_CNT_W)) u_wdt_div (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.tick_in  (st_ff.core_t),
		.shift    (WDT_SHIFT),
		.tick_out (core_quarter_tick)
	);

	// Watchdog source change is glitch-free too; it waits for one tick of the old source
	spm_tick_sw u_wdt_sw (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.tick_a   (core_quarter_tick),
		.tick_b   (st_ff.sub_t),
		.sel      (wdt_src_sub),
		.tick_out (wdt_mux_tick),
		.cur_sel  ()
	);

	// Mode sequencing, clock gating and the bus slave
	always_comb begin
		nxt_st = st_ff;
		case (st_ff.mode)
			M_FULL: begin
				nxt_st.fast_en = 1'b1;
				if (req_low) begin
					nxt_st.mode = M_LOW;
				end
			end
			M_LOW: begin
				nxt_st.fast_en = !cur_low;
				if (!req_low) begin
					nxt_st.mode    = M_FULL;
					nxt_st.fast_en = 1'b1;
				end
			end
			M_DOZE1: begin
				nxt_st.fast_en = st_ff.fast_en;
			end
			M_WAKE: begin
				nxt_st.fast_en = 1'b1;
				if (fast_tick) begin
					nxt_st.wake_cnt = st_ff.wake_cnt + 1'b1;
					if (st_ff.wake_cnt == WAKE_CNT_W'(WAKE_SETTLE - 1)) begin
						nxt_st.mode = M_FULL;
					end
				end
			end
			M_DOZE0, M_DEEP, M_LIGHT: begin
				nxt_st.fast_en = 1'b0;
			end
			default: begin
				nxt_st.mode = M_FULL;
			end
		endcase
		// Halt from a running mode picks the stop mode
		if (halt_req && (st_ff.mode inside {M_FULL, M_LOW})) begin
			if (doze_on_halt) begin
				nxt_st.mode = core_clk_keep ? M_DOZE1 : M_DOZE0;
			end else if (brownout_detect_on || (wdt_enable && wdt_src_sub)) begin
				nxt_st.mode = M_LIGHT;
			end else begin
				nxt_st.mode = M_DEEP;
			end
		end
		// Wake: low clock resumes directly, a stopped fast oscillator resumes via the substitute clock
		if (wake_req && stop_mode) begin
			nxt_st.wake_cnt = '0;
			if (req_low) begin
				nxt_st.mode = M_LOW;
			end else if (st_ff.mode == M_DOZE1 && st_ff.fast_en) begin
				nxt_st.mode = M_FULL;
			end else begin
				nxt_st.mode    = M_WAKE;
				nxt_st.fast_en = 1'b1;
			end
		end
		// Clock outputs; the CPU sees nothing in any stop mode
		nxt_st.core_t = core_src_tick && (st_ff.mode inside {M_FULL, M_LOW, M_DOZE1});
		nxt_st.cpu_t  = (core_src_tick && (st_ff.mode inside {M_FULL, M_LOW})) ||
			(low_rc_osc && st_ff.mode == M_WAKE);
		nxt_st.sub_t  = low_rc_osc && st_ff.mode != M_DEEP;
		nxt_st.wds_t  = low_rc_osc && st_ff.mode != M_DEEP;
		nxt_st.tbc_t  = low_rc_osc && !(st_ff.mode inside {M_DEEP, M_LIGHT});
		nxt_st.wdt_t  = wdt_mux_tick && wdt_enable && st_ff.mode != M_DEEP;

		// Write channel: address and data taken in either order, answered when both are in
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_st.aw_got  = 1'b1;
			nxt_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_st.w_got  = 1'b1;
			nxt_st.w_data = s_axi_wdata;
			nxt_st.w_strb = s_axi_wstrb;
		end
		if (st_ff.aw_got && st_ff.w_got) begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got  = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp  = RESP_OKAY;
			if (st_ff.aw_addr == ADDR_CTRL) begin
				if (st_ff.w_strb[0]) begin
					nxt_st.ctrl[7:0] = st_ff.w_data[7:0];
				end
				if (st_ff.w_strb[1]) begin
					nxt_st.ctrl[CTRL_W-1:8] = st_ff.w_data[CTRL_W-1:8];
				end
			end else if (st_ff.aw_addr != ADDR_STATUS) begin
				nxt_st.bresp = RESP_SLVERR;
			end
		end
		if (st_ff.bvalid && s_axi_bready) begin
			nxt_st.bvalid = 1'b0;
		end
		// Read channel
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp  = RESP_OKAY;
			nxt_st.rdata  = '0;
			if (s_axi_araddr == ADDR_CTRL) begin
				nxt_st.rdata[CTRL_W-1:0] = st_ff.ctrl;
			end else if (s_axi_araddr == ADDR_STATUS) begin
				nxt_st.rdata[6:0]        = st_ff.mode;
				nxt_st.rdata[ST_CUR_LOW] = cur_low;
				nxt_st.rdata[ST_FAST_ON] = st_ff.fast_en;
			end else begin
				nxt_st.rresp = RESP_SLVERR;
			end
		end else if (st_ff.rvalid && s_axi_rready) begin
			nxt_st.rvalid = 1'b0;
		end
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff         <= '0;
			st_ff.mode    <= M_FULL;
			st_ff.ctrl    <= CTRL_RST;
			st_ff.fast_en <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Handshakes: one write and one read outstanding at a time
	assign s_axi_awready       = !st_ff.aw_got && !st_ff.bvalid;
	assign s_axi_wready        = !st_ff.w_got && !st_ff.bvalid;
	assign s_axi_arready       = !st_ff.rvalid;
	assign s_axi_bvalid        = st_ff.bvalid;
	assign s_axi_bresp         = st_ff.bresp;
	assign s_axi_rvalid        = st_ff.rvalid;
	assign s_axi_rdata         = st_ff.rdata;
	assign s_axi_rresp         = st_ff.rresp;
	assign core_clock          = st_ff.core_t;
	assign cpu_clock           = st_ff.cpu_t;
	assign substitute_clock    = st_ff.sub_t;
	assign watchdog_side_clock = st_ff.wds_t;
	assign periodic_tick_clock = st_ff.tbc_t;
	assign wdt_clock           = st_ff.wdt_t;
	assign fast_osc_en         = st_ff.fast_en;
	assign wdt_disable         = st_ff.mode == M_DEEP;
	assign mode_status         = st_ff.mode;

	// Stop modes
	sequence s_halt_deep;
		(st_ff.mode inside {M_FULL, M_LOW}) && halt_req && !doze_on_halt && !brownout_detect_on && !wdt_enable;
	endsequence
	sequence s_halt_doze(logic keep);
		(st_ff.mode inside {M_FULL, M_LOW}) && halt_req && doze_on_halt && core_clk_keep == keep && !wake_req;
	endsequence

	a_cpu_stopped: assert property (@(posedge aclk) disable iff (!aresetn)
		(stop_mode && $past(stop_mode)) |-> !cpu_clock) else $error("cpu clock in stop mode");
	a_deep_all_off: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_ff.mode == M_DEEP && $past(st_ff.mode) == M_DEEP) |->
		!substitute_clock && !watchdog_side_clock && !periodic_tick_clock && !wdt_clock && wdt_disable)
		else $error("clock running in deep sleep");
	a_bod_no_deep: assert property (@(posedge aclk) disable iff (!aresetn)
		(halt_req && !doze_on_halt && brownout_detect_on && (st_ff.mode inside {M_FULL, M_LOW}) && !wake_req)
		|=> st_ff.mode == M_LIGHT) else $error("deep sleep with brownout detect on");
	a_halt_deep: assert property (@(posedge aclk) disable iff (!aresetn)
		s_halt_deep and !wake_req |=> st_ff.mode == M_DEEP ##1 !fast_osc_en) else $error("halt did not reach deep sleep");
	a_halt_doze0: assert property (@(posedge aclk) disable iff (!aresetn)
		s_halt_doze(1'b0) |=> st_ff.mode == M_DOZE0 ##1 (!fast_osc_en && !core_clock))
		else $error("doze without oscillator entered wrongly");
	a_halt_doze1: assert property (@(posedge aclk) disable iff (!aresetn)
		s_halt_doze(1'b1) and fast_osc_en |=> st_ff.mode == M_DOZE1 ##1 fast_osc_en)
		else $error("doze with oscillator lost the oscillator");
	a_slow_fast_off: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_ff.mode == M_LOW && cur_low && !wake_req && !halt_req && req_low) |=> !fast_osc_en)
		else $error("fast oscillator left on in low-speed run");
	a_wake_sub: assert property (@(posedge aclk) disable iff (!aresetn)
		(st_ff.mode == M_WAKE && low_rc_osc) |=> cpu_clock && substitute_clock)
		else $error("cpu not on substitute clock after wake");
	a_tick_from_low: assert property (@(posedge aclk) disable iff (!aresetn)
		periodic_tick_clock |-> $past(low_rc_osc) && !($past(st_ff.mode) inside {M_DEEP, M_LIGHT}))
		else $error("tick clock without low oscillator");
endmodule : spm_power_mode_ctrl
`default_nettype wire

/* rtl/spm_tick_div.sv */
// Divides a tick strobe by a power of two.
// Assumes ticks are one-cycle strobes on aclk; a new ratio is taken only at a count wrap.
`timescale 1ns/1ps
`default_nettype none
module spm_tick_div
	import spm_pkg::*;
#(
	parameter int unsigned CNT_W = DIV_CNT_W
) (
	input  wire logic               aclk,
	input  wire logic               aresetn,
	input  wire logic               tick_in,
	input  wire logic [SHIFT_W-1:0] shift,
	output var  logic               tick_out
);
	typedef struct packed {
		logic [CNT_W-1:0]   cnt;
		logic [SHIFT_W-1:0] shift_cur;
		logic               out;
	} spm_div_st_t;

	spm_div_st_t st_ff;
	spm_div_st_t nxt_st;

	// Ratio changes wait for the wrap so no shortened period escapes
	always_comb begin
		nxt_st     = st_ff;
		nxt_st.out = 1'b0;
		if (tick_in) begin
			if (st_ff.cnt == ~({CNT_W{1'b1}} << st_ff.shift_cur)) begin
				nxt_st.out       = 1'b1;
				nxt_st.cnt       = '0;
				nxt_st.shift_cur = shift;
			end else begin
				nxt_st.cnt = st_ff.cnt + 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tick_out = st_ff.out;
endmodule : spm_tick_div
`default_nettype wire

/* rtl/spm_tick_sw.sv */
// Glitch-free switch between two tick strobes.
// Assumes the old source keeps ticking until one of its ticks has passed after a change request.
`timescale 1ns/1ps
`default_nettype none
module spm_tick_sw (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic tick_a,
	input  wire logic tick_b,
	input  wire logic sel,
	output var  logic tick_out,
	output var  logic cur_sel
);
	typedef enum logic [2:0] {
		SW_STEADY = 3'h1,
		SW_OLD    = 3'h2,
		SW_DROP   = 3'h4
	} spm_sw_ph_t;

	typedef struct packed {
		spm_sw_ph_t ph;
		logic       cur;
		logic       out;
	} spm_sw_st_t;

	spm_sw_st_t st_ff;
	spm_sw_st_t nxt_st;
	logic       cur_tick;

	// Old source ends on its own tick, first new tick is dropped: no interval below either period
	always_comb begin
		nxt_st     = st_ff;
		nxt_st.out = 1'b0;
		cur_tick   = st_ff.cur ? tick_b : tick_a;
		case (st_ff.ph)
			SW_STEADY: begin
				nxt_st.out = cur_tick;
				if (sel != st_ff.cur) begin
					nxt_st.ph = SW_OLD;
				end
			end
			SW_OLD: begin
				if (cur_tick) begin
					nxt_st.out = 1'b1;
					nxt_st.cur = ~st_ff.cur;
					nxt_st.ph  = SW_DROP;
				end
			end
			SW_DROP: begin
				if (cur_tick) begin
					nxt_st.ph = SW_STEADY;
				end
			end
			default: begin
				nxt_st.ph = SW_STEADY;
			end
		endcase
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= '{ph: SW_STEADY, cur: 1'b0, out: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign tick_out = st_ff.out;
	assign cur_sel  = st_ff.cur;
endmodule : spm_tick_sw
`default_nettype wire

/* tb/tb_spm_power_mode_ctrl.sv */
// Self-checking bench for the core clock and power mode controller: bus, divider, side clocks, modes.
// Assumes the controller alone on its AXI4-Lite port; oscillators are modelled as tick strobes on aclk.
`timescale 1ns/1ps
`default_nettype none
module tb_spm_power_mode_ctrl
	import spm_pkg::*;
;
	localparam int FP = 4;    // Fast RC tick spacing in aclk cycles
	localparam int LP = 16;   // Low RC tick spacing in aclk cycles
	localparam int W  = 1024; // Measuring window in cycles

	logic        aclk;
	logic        aresetn;
	logic [3:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [3:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic        xt;
	logic        frc;
	logic        lrc;
	logic        halt_req;
	logic        wake_req;
	logic [5:0]  clks;
	logic        fast_osc_en;
	logic        wdt_disable;
	logic [6:0]  mode_status;
	int          errors;
	int          checks;
	int          cnt[6];
	int          osc_t = 0;
	int          gap = 100;
	int          short_gaps = 0;

	spm_power_mode_ctrl #(.USE_CRYSTAL(1'b0), .WAKE_SETTLE(8)) i_spm_power_mode_ctrl (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.crystal_osc(xt), .fast_rc_osc(frc), .low_rc_osc(lrc), .halt_req(halt_req), .wake_req(wake_req),
		.core_clock(clks[4]), .cpu_clock(clks[3]), .substitute_clock(clks[2]),
		.watchdog_side_clock(clks[5]), .periodic_tick_clock(clks[1]), .wdt_clock(clks[0]),
		.fast_osc_en(fast_osc_en), .wdt_disable(wdt_disable), .mode_status(mode_status)
	);

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// Oscillator strobes; crystal runs too although the build uses the fast RC
	always @(posedge aclk) begin
		osc_t <= osc_t + 1;
		xt    <= (osc_t % 3) == 2;
		frc   <= (osc_t % FP) == FP - 1;
		lrc   <= (osc_t % LP) == LP - 1;
	end

	// Core ticks closer than one fast period would be a clipped pulse
	always @(negedge aclk) begin
		if (clks[4] === 1'b1) begin
			if (gap < FP - 1 && aresetn) short_gaps++;
			gap = 0;
		end else begin
			gap++;
		end
	end

	task automatic wrap_up;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Tick counts may differ by one at the window edges; a stopped clock must show none
	task automatic chk_n(input string what, input int exp, input int got);
		int tol;
		tol = (exp > 0) ? 1 : 0;
		checks++;
		if (got < exp - tol || got > exp + tol) begin
			errors++;
			$display("wrong value %s expected %0d seen %0d", what, exp, got);
		end
	endtask : chk_n

	task automatic tmo(input int i);
		if (i > 300) begin
			errors++;
			$display("wrong value wait expected done seen timeout");
			wrap_up();
		end
	endtask : tmo

	// Readies are combinational, so they are read at the falling edge before the taking edge
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		logic at, wt, bt;
		int   i;
		i = 0;
		bt = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!bt) begin
			@(negedge aclk);
			at = awvalid && awready;
			wt = wvalid && wready;
			bt = bvalid;
			r = bresp;
			@(posedge aclk);
			if (at) awvalid <= 1'b0;
			if (wt) wvalid <= 1'b0;
			i++;
			tmo(i);
		end
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		logic at, rt;
		int   i;
		i = 0;
		rt = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!rt) begin
			@(negedge aclk);
			at = arvalid && arready;
			rt = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (at) arvalid <= 1'b0;
			i++;
			tmo(i);
		end
		rready <= 1'b0;
	endtask : axi_rd

	task automatic wr_ctrl(input logic [8:0] v);
		logic [1:0] r;
		axi_wr(ADDR_CTRL, {16'($urandom), 7'h00, v}, 4'hf, r);
		chk("ctrl bresp", 32'(RESP_OKAY), 32'(r));
	endtask : wr_ctrl

	task automatic measure(input int n);
		cnt = '{default: 0};
		repeat (n) begin
			@(negedge aclk);
			for (int k = 0; k < 6; k++) cnt[k] += int'(clks[k] === 1'b1);
		end
	endtask : measure

	task automatic pulse(input bit wake);
		@(posedge aclk);
		if (wake) wake_req <= 1'b1;
		else halt_req <= 1'b1;
		@(posedge aclk);
		halt_req <= 1'b0;
		wake_req <= 1'b0;
		@(negedge aclk);
	endtask : pulse

	function automatic int exp_core(input logic fs, input logic [2:0] dv);
		if (fs) return W / FP;
		if (dv <= 3'd1) return W / LP;
		return (W / FP) >> (8 - int'(dv));
	endfunction : exp_core

	// Halt cases: control word, stop mode, side clocks on, mode after wake
	logic [8:0] hc[7] = '{9'h011, 9'h031, 9'h041, 9'h181, 9'h001, 9'h081, 9'h010};
	logic [6:0] hm[7] = '{7'h04, 7'h08, 7'h20, 7'h20, 7'h10, 7'h10, 7'h04};
	logic [6:0] hw[7] = '{7'h40, 7'h01, 7'h40, 7'h40, 7'h40, 7'h40, 7'h02};
	bit         hs[7] = '{1, 1, 1, 1, 0, 0, 1};
	bit         ht[7] = '{1, 1, 0, 0, 0, 0, 1};

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic        fs;
		logic        low;
		int          i;
		{aresetn, awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
		{araddr, arvalid, rready, halt_req, wake_req, errors, checks} = '0;
		void'($urandom(32'hdf6530bf));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk("mode after reset", 32'h01, 32'(mode_status));
		axi_rd(ADDR_CTRL, d, r);
		chk("ctrl reset", 32'(CTRL_RST), d);
		// Lane 1 disabled: bit 8 must not land
		axi_wr(ADDR_CTRL, 32'h0000_0101, 4'h1, r);
		axi_rd(ADDR_CTRL, d, r);
		chk("ctrl lane", 32'h0000_0001, d);
		axi_wr(4'h8, 32'h0000_01ff, 4'hf, r);
		chk("unmapped bresp", 32'(RESP_SLVERR), 32'(r));
		axi_rd(4'hc, d, r);
		chk("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
		chk("unmapped rdata", 32'h0, d);
		// Every divider code, then fast /1
		for (int k = 0; k < 9; k++) begin
			fs = (k == 8);
			low = !fs && k <= 1;
			wr_ctrl({5'h00, 3'(k), fs});
			repeat (600) @(posedge aclk);
			measure(W);
			chk_n("core ticks", exp_core(fs, 3'(k)), cnt[4]);
			chk_n("cpu ticks", exp_core(fs, 3'(k)), cnt[3]);
			chk_n("substitute ticks", W / LP, cnt[2]);
			chk_n("periodic ticks", W / LP, cnt[1]);
			chk("run mode", low ? 32'h02 : 32'h01, 32'(mode_status));
			chk("fast enable", 32'(!low), 32'(fast_osc_en));
			chk_n("side ticks", W / LP, cnt[5]);
			axi_rd(ADDR_STATUS, d, r);
			chk("status", {23'h0, !low, low, low ? 7'h02 : 7'h01}, d);
		end
		// Watchdog on core/4 with core at fast/4, then on the substitute clock
		wr_ctrl(9'h08c);
		repeat (600) @(posedge aclk);
		measure(W);
		chk_n("wdt ticks core", W / (FP * 16), cnt[0]);
		wr_ctrl(9'h18c);
		repeat (600) @(posedge aclk);
		measure(W);
		chk_n("wdt ticks sub", W / LP, cnt[0]);
		// Halt into each stop mode, then wake
		for (int k = 0; k < 7; k++) begin
			wr_ctrl(hc[k]);
			repeat (600 + $urandom_range(0, 40)) @(posedge aclk);
			pulse(1'b0);
			chk("stop mode", 32'(hm[k]), 32'(mode_status));
			repeat (100) @(posedge aclk);
			measure(W);
			chk_n("stop cpu ticks", 0, cnt[3]);
			chk_n("stop core ticks", k == 1 ? W / FP : 0, cnt[4]);
			chk_n("stop substitute", hs[k] ? W / LP : 0, cnt[2]);
			chk_n("stop periodic", ht[k] ? W / LP : 0, cnt[1]);
			chk_n("stop side clock", hs[k] ? W / LP : 0, cnt[5]);
			chk_n("stop wdt ticks", k == 3 ? W / LP : 0, cnt[0]);
			chk("wdt disable", 32'(hm[k] == 7'h10), 32'(wdt_disable));
			pulse(1'b1);
			chk("wake mode", 32'(hw[k]), 32'(mode_status));
			if (hw[k] == 7'h40) begin
				i = 0;
				cnt[3] = 0;
				while (mode_status !== 7'h01) begin
					@(negedge aclk);
					cnt[3] += int'(clks[3] === 1'b1);
					i++;
					tmo(i);
				end
				chk("cpu on substitute", 32'h1, 32'(cnt[3] > 0));
			end
		end
		chk("short core gaps", 32'h0, 32'(short_gaps));
		wrap_up();
	end
endmodule : tb_spm_power_mode_ctrl
`default_nettype wire
